// >>> hdl/ioexp_consts.svh
// constants for the serial io expander
`ifndef IOEXP_CONSTS_SVH
`define IOEXP_CONSTS_SVH
`define IOEXP_ADDR_FIXED     4'h4
`define IOEXP_GENERAL_CALL   7'h00
`define IOEXP_PORT_RESET     16'hFFFF
`define IOEXP_CLK_MHZ        200
`define IOEXP_ALERT_VALID_NS 4000
`define IOEXP_ALERT_CLEAR_NS 4000
`define IOEXP_OUTPUT_VALID_NS 4000
`define IOEXP_ALERT_VALID_CYC ((`IOEXP_ALERT_VALID_NS * `IOEXP_CLK_MHZ) / 1000)
`define IOEXP_FIFO_DEPTH     32
`endif

// >>> hdl/ioexp_pkg.sv
// types for the serial io expander
package ioexp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK,
        ST_IGNORE
    } ioexp_state_t;

    typedef struct packed {
        logic [7:0] low_port_pins;
        logic [7:0] high_port_pins;
    } ioexp_word_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } ioexp_bus_t;
endpackage

// >>> hdl/ioexp_fifo.sv
// fifo between the write byte path and the port latch
`timescale 1ns/1ps
`default_nettype none
module ioexp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } ioexp_fifo_st_t;

    ioexp_fifo_st_t   st_ff;
    ioexp_fifo_st_t   nxt_st;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (st_ff.cnt != DEPTH[AW:0]);
    assign out_valid = (st_ff.cnt != '0);
    assign out_data  = mem_ff[st_ff.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
        if (push) begin
            mem_ff[st_ff.wr] <= in_data;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/ioexp_top.sv
// serial bus slave with 16 quasi-bidirectional port pins and alert
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_consts.svh"
// Notes on behaviour
// RQ1 - any input pin edge pulls the alert low within 4 us
// RQ2 - pins returning to their prior levels release and rearm the alert
// RQ3 - own access clears alert at ack: read after rise, write after fall
// RQ4 - traffic to other slaves leaves the alert untouched
// RQ5 - changes during the ack pulse may be missed; later ones are seen
// RQ6 - alert is open drain: only pulls low or floats
// RQ7 - data bytes come in pairs: first low port, second high port
// RQ8 - ack address and both bytes; update all 16 outputs after second ack
// RQ9 - unlimited pairs per write, each pair replaces the outputs
// RQ10 - new outputs appear within 4 us of the ack clock rising edge
// RQ11 - only complete, acknowledged bytes change the outputs
// RQ12 - read returns sampled pin levels, low port first, in pairs
// RQ13 - master writes ones to input pins before reading them
// RQ14 - general call address is not acknowledged
// RQ15 - address msb first, direction last; ack holds sda low on match
// RQ16 - address straps stay steady from start to stop
// RQ17 - start is sda fall with scl high, stop is sda rise with scl high
// RQ18 - master nacks the last read byte; device then releases sda
// RQ19 - transmitter releases sda after each byte for one ack bit
// RQ20 - reset idles the bus logic and sets every pin weak high
// RQ21 - address is 0100 then straps 2,1,0
// RQ22 - a written 0 drives low, a written 1 only weak high
module ioexp_top
    import ioexp_pkg::*;
#(
    parameter int ALERT_CYC = `IOEXP_ALERT_VALID_CYC
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_N,
    input  wire logic        ADDR_STRAP_0,
    input  wire logic        ADDR_STRAP_1,
    input  wire logic        ADDR_STRAP_2,
    input  wire logic [15:0] PORT_IN,
    output logic      [15:0] PORT_OUT,
    output logic      [15:0] PORT_STRONG_OE_N,
    output logic      [15:0] PORT_WEAK_HIGH,
    output logic             ALERT_OUT,
    output logic             ALERT_OE_N
);
    import ioexp_pkg::*;

    typedef struct packed {
        ioexp_bus_t   s1;
        ioexp_bus_t   s2;
        ioexp_bus_t   prev;
        logic [2:0]   strap1;
        logic [2:0]   strap2;
        logic [15:0]  pin1;
        logic [15:0]  pin2;
        logic [15:0]  ref_pins;
        ioexp_state_t state;
        logic [3:0]   bitcnt;
        logic [7:0]   shreg;
        logic         rnw;
        logic         hi_byte;
        logic [7:0]   low_hold;
        logic [15:0]  rd_word;
        logic [15:0]  latch;
        logic         sda_low;
        logic         alert;
        logic         clr_pend;
    } ioexp_st_t;

    ioexp_st_t   st_ff;
    ioexp_st_t   nxt_st;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic [6:0]  my_addr;
    logic        f_in_valid;
    logic        f_in_ready;
    logic [15:0] f_in_data;
    logic        f_out_valid;
    logic [15:0] f_out_data;

    assign scl_rise  = st_ff.s2.scl && !st_ff.prev.scl;
    assign scl_fall  = !st_ff.s2.scl && st_ff.prev.scl;
    assign start_det = st_ff.s2.scl && st_ff.prev.scl
                       && st_ff.prev.sda && !st_ff.s2.sda; // RQ17
    assign stop_det  = st_ff.s2.scl && st_ff.prev.scl
                       && !st_ff.prev.sda && st_ff.s2.sda; // RQ17
    assign my_addr   = {`IOEXP_ADDR_FIXED, st_ff.strap2}; // RQ21

    ioexp_fifo #(
        .WIDTH (16),
        .DEPTH (`IOEXP_FIFO_DEPTH)
    ) u_fifo (
        .clk       (CORE_CLK),
        .rst_n     (RESETN),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (1'b1),
        .out_data  (f_out_data)
    );

    always_comb begin
        nxt_st        = st_ff;
        f_in_valid    = 1'b0;
        f_in_data     = {st_ff.shreg, st_ff.low_hold};
        nxt_st.s1     = '{scl: SCL, sda: SDA_IN};
        nxt_st.s2     = st_ff.s1;
        nxt_st.prev   = st_ff.s2;
        nxt_st.strap1 = {ADDR_STRAP_2, ADDR_STRAP_1, ADDR_STRAP_0};
        nxt_st.strap2 = st_ff.strap1;
        nxt_st.pin1   = PORT_IN;
        nxt_st.pin2   = st_ff.pin1;
        // alert: any change against reference, cleared back on return
        nxt_st.alert  = (st_ff.pin2 != st_ff.ref_pins); // RQ1 RQ2
        if (st_ff.clr_pend) begin
            nxt_st.ref_pins = st_ff.pin2; // RQ3 RQ5
            nxt_st.alert    = 1'b0;
            nxt_st.clr_pend = 1'b0;
        end
        if (f_out_valid) begin
            nxt_st.latch = f_out_data; // RQ8 RQ10
        end
        if (start_det) begin
            nxt_st.state   = ST_ADDR;
            nxt_st.bitcnt  = '0;
            nxt_st.sda_low = 1'b0;
        end else if (stop_det) begin
            nxt_st.state   = ST_IDLE; // RQ11
            nxt_st.sda_low = 1'b0;
        end else begin
            case (st_ff.state)
                ST_ADDR, ST_WR_BYTE: begin
                    if (scl_rise) begin
                        nxt_st.shreg  = {st_ff.shreg[6:0], st_ff.s2.sda}; // RQ15
                        nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
                    end else if (scl_fall && st_ff.bitcnt == 4'h8) begin
                        nxt_st.bitcnt = '0;
                        if (st_ff.state == ST_ADDR) begin
                            if (st_ff.shreg[7:1] == my_addr
                                && my_addr != `IOEXP_GENERAL_CALL) begin // RQ14
                                nxt_st.sda_low = 1'b1; // RQ15
                                nxt_st.rnw     = st_ff.shreg[0];
                                nxt_st.state   = ST_ADDR_ACK;
                                nxt_st.hi_byte = 1'b0;
                            end else begin
                                nxt_st.state = ST_IGNORE; // RQ4
                            end
                        end else if (f_in_ready) begin
                            nxt_st.sda_low = 1'b1; // RQ8
                            nxt_st.state   = ST_WR_ACK;
                        end else begin
                            nxt_st.state = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_rise) begin
                        if (st_ff.rnw) begin
                            nxt_st.clr_pend = 1'b1; // RQ3
                        end
                        if (st_ff.state == ST_WR_ACK) begin
                            if (st_ff.hi_byte) begin
                                f_in_valid = 1'b1; // RQ7 RQ9 RQ10
                            end else begin
                                nxt_st.low_hold = st_ff.shreg; // RQ7
                            end
                            nxt_st.hi_byte = !st_ff.hi_byte;
                        end
                    end else if (scl_fall) begin
                        nxt_st.sda_low = 1'b0; // RQ19
                        if (!st_ff.rnw) begin
                            nxt_st.clr_pend = 1'b1; // RQ3
                        end
                        if (st_ff.rnw) begin
                            nxt_st.rd_word = st_ff.pin2; // RQ12
                            nxt_st.sda_low = !st_ff.pin2[7];
                            nxt_st.shreg   = {st_ff.pin2[6:0], 1'b0};
                            nxt_st.hi_byte = 1'b0;
                            nxt_st.state   = ST_RD_BYTE;
                        end else begin
                            nxt_st.state = ST_WR_BYTE;
                        end
                    end
                end
                ST_RD_BYTE: begin
                    if (scl_fall) begin
                        if (st_ff.bitcnt == 4'h7) begin
                            nxt_st.sda_low = 1'b0; // RQ19
                            nxt_st.bitcnt  = '0;
                            nxt_st.state   = ST_RD_ACK;
                        end else begin
                            nxt_st.sda_low = !st_ff.shreg[7];
                            nxt_st.shreg   = {st_ff.shreg[6:0], 1'b0};
                            nxt_st.bitcnt  = st_ff.bitcnt + 4'h1;
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        if (st_ff.s2.sda) begin
                            nxt_st.state = ST_IGNORE; // RQ18
                        end else begin
                            nxt_st.clr_pend = 1'b1; // RQ3
                        end
                    end else if (scl_fall) begin
                        nxt_st.state   = ST_RD_BYTE;
                        nxt_st.hi_byte = !st_ff.hi_byte;
                        if (st_ff.hi_byte) begin
                            nxt_st.rd_word = st_ff.pin2; // RQ12
                            nxt_st.sda_low = !st_ff.pin2[7];
                            nxt_st.shreg   = {st_ff.pin2[6:0], 1'b0};
                        end else begin
                            nxt_st.sda_low = !st_ff.rd_word[15];
                            nxt_st.shreg   = {st_ff.rd_word[14:8], 1'b0};
                        end
                    end
                end
                default: begin
                    nxt_st.sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            st_ff          <= '0;
            st_ff.s1       <= '{scl: 1'b1, sda: 1'b1};
            st_ff.s2       <= '{scl: 1'b1, sda: 1'b1};
            st_ff.prev     <= '{scl: 1'b1, sda: 1'b1};
            st_ff.pin1     <= `IOEXP_PORT_RESET;
            st_ff.pin2     <= `IOEXP_PORT_RESET;
            st_ff.ref_pins <= `IOEXP_PORT_RESET;
            st_ff.latch    <= `IOEXP_PORT_RESET; // RQ20
            st_ff.rd_word  <= `IOEXP_PORT_RESET;
            st_ff.state    <= ST_IDLE; // RQ20
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            SDA_OUT          <= 1'b0;
            SDA_OE_N         <= 1'b1;
            PORT_OUT         <= `IOEXP_PORT_RESET;
            PORT_STRONG_OE_N <= 16'hFFFF;
            PORT_WEAK_HIGH   <= 16'hFFFF;
            ALERT_OUT        <= 1'b0;
            ALERT_OE_N       <= 1'b1;
        end else begin
            SDA_OUT          <= 1'b0;
            SDA_OE_N         <= !nxt_st.sda_low;
            PORT_OUT         <= nxt_st.latch; // RQ22
            PORT_STRONG_OE_N <= nxt_st.latch; // RQ22
            PORT_WEAK_HIGH   <= nxt_st.latch; // RQ22
            ALERT_OUT        <= 1'b0; // RQ6
            ALERT_OE_N       <= !nxt_st.alert; // RQ6
        end
    end
endmodule
`default_nettype wire

// >>> bench/ioexp_master.sv
// bus master model driving scl and pulling sda
`timescale 1ns/1ps
`default_nettype none
module ioexp_master (
    output logic      scl,
    output logic      sda_oe_n,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end
    // non-blocking drives: some steps land on a core clock edge
    task automatic bus_start();
        sda_oe_n <= 1'b1;
        #32 scl <= 1'b1;
        #32 sda_oe_n <= 1'b0;
        #32 scl <= 1'b0;
    endtask
    task automatic bus_stop();
        #16 sda_oe_n <= 1'b0;
        #16 scl <= 1'b1;
        #32 sda_oe_n <= 1'b1;
        #64;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #16 sda_oe_n <= b[i];
            #16 scl <= 1'b1;
            #32 scl <= 1'b0;
        end
        #16 sda_oe_n <= 1'b1;
        #16 scl <= 1'b1;
        #16 ack = !sda;
        #16 scl <= 1'b0;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #32 scl <= 1'b1;
            #16 b[i] = sda;
            #16 scl <= 1'b0;
        end
        #16 sda_oe_n <= last;
        #16 scl <= 1'b1;
        #32 scl <= 1'b0;
        #16 sda_oe_n <= 1'b1;
        #16;
    endtask
endmodule
`default_nettype wire

// >>> bench/ioexp_top_props.sv
// assertions on the serial io expander ports
`timescale 1ns/1ps
`default_nettype none
module ioexp_top_props #(
    parameter int ALERT_CYC = 800
) (
    input wire logic        CORE_CLK,
    input wire logic        RESETN,
    input wire logic        SCL,
    input wire logic        SDA_OUT,
    input wire logic        SDA_OE_N,
    input wire logic [15:0] PORT_IN,
    input wire logic [15:0] PORT_OUT,
    input wire logic [15:0] PORT_STRONG_OE_N,
    input wire logic [15:0] PORT_WEAK_HIGH,
    input wire logic        ALERT_OUT,
    input wire logic        ALERT_OE_N
);
    int since_in_ff;
    int since_lo_ff;
    int since_scl_ff;
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            since_in_ff <= 0;
            since_lo_ff <= 99;
            since_scl_ff <= 0;
        end else begin
            since_in_ff <= $changed(PORT_IN) ? 0 : since_in_ff + 1;
            since_lo_ff <= !SDA_OE_N ? 0 : since_lo_ff + 1;
            since_scl_ff <= $changed(SCL) ? 0 : since_scl_ff + 1;
        end
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);
    sequence pin_edge;
        ALERT_OE_N && since_scl_ff > 12 && since_in_ff > 12
            && $changed(PORT_IN);
    endsequence
    sequence pin_settle;
        ($stable(PORT_IN) && SCL)[*8];
    endsequence
    sequence ack_rise;
        $rose(SCL) && !SDA_OE_N;
    endsequence
    a_alert_sets: assert property (pin_edge ##1 pin_settle
        |-> ##[0:4] !ALERT_OE_N) else $error("alert missing");
    a_alert_cause: assert property ($fell(ALERT_OE_N)
        |-> since_in_ff < ALERT_CYC) else $error("alert without cause");
    a_alert_holds: assert property (!ALERT_OE_N && since_in_ff > 12
        && since_scl_ff > 12 |=> !ALERT_OE_N) else $error("alert lost");
    a_ack_holds: assert property (ack_rise
        |=> (!SDA_OE_N)[*5]) else $error("sda low not held");
    a_sda_moves: assert property ($changed(SDA_OE_N)
        |-> !SCL && !$past(SCL)) else $error("sda moved in scl high");
    a_bus_idle_free: assert property (since_scl_ff > 12
        |-> SDA_OE_N) else $error("sda held on idle bus");
    a_port_after_ack: assert property ($changed(PORT_OUT)
        |-> since_lo_ff < 20) else $error("port moved without ack");
    a_drive_matches: assert property (PORT_STRONG_OE_N == PORT_OUT
        && (PORT_WEAK_HIGH & PORT_OUT) == PORT_OUT)
        else $error("pin drive differs from latch");
    a_open_drain: assert property (!ALERT_OUT && !SDA_OUT)
        else $error("open drain output driven high");
endmodule
bind ioexp_top ioexp_top_props #(.ALERT_CYC(ALERT_CYC)) i_ioexp_top_props (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SCL(SCL), .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N), .PORT_IN(PORT_IN), .PORT_OUT(PORT_OUT),
    .PORT_STRONG_OE_N(PORT_STRONG_OE_N), .PORT_WEAK_HIGH(PORT_WEAK_HIGH),
    .ALERT_OUT(ALERT_OUT), .ALERT_OE_N(ALERT_OE_N)
);
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the serial io expander
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk;
    logic        rst_n;
    logic [2:0]  strap;
    logic [15:0] ext;
    logic        m_scl;
    logic        m_oe_n;
    logic        s_oe_n;
    logic        ack;
    logic [7:0]  rx;
    logic        alert_n;
    logic [15:0] p_out;
    logic [15:0] p_oe_n;
    wire logic   sda = m_oe_n & s_oe_n;
    wire logic [15:0] pins = ext & p_oe_n;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    ioexp_top i_ioexp_top (
        .CORE_CLK(clk), .RESETN(rst_n), .SCL(m_scl), .SDA_IN(sda),
        .SDA_OUT(), .SDA_OE_N(s_oe_n), .ADDR_STRAP_0(strap[0]),
        .ADDR_STRAP_1(strap[1]), .ADDR_STRAP_2(strap[2]), .PORT_IN(pins),
        .PORT_OUT(p_out), .PORT_STRONG_OE_N(p_oe_n), .PORT_WEAK_HIGH(),
        .ALERT_OUT(), .ALERT_OE_N(alert_n)
    );
    ioexp_master i_ioexp_master (.scl(m_scl), .sda_oe_n(m_oe_n), .sda(sda));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_alert(logic lvl);
        for (int n = 0; n < 800 && alert_n !== lvl; n++) @(posedge clk);
        chk("alert", {15'h0, lvl}, {15'h0, alert_n});
    endtask
    task automatic put(logic [7:0] b, logic exp);
        i_ioexp_master.put_byte(b, ack);
        chk("ack", {15'h0, exp}, {15'h0, ack});
    endtask
    task automatic port_is(logic [15:0] exp);
        repeat (20) @(posedge clk);
        chk("port", exp, p_out);
    endtask
    task automatic xfer(logic [7:0] adr, logic ok);
        i_ioexp_master.bus_start();
        put(adr, ok);
    endtask
    task automatic rd(logic [7:0] lo, logic [7:0] hi);
        xfer(8'h4B, 1'b1);
        i_ioexp_master.get_byte(1'b0, rx);
        chk("low byte", {8'h00, lo}, {8'h00, rx});
        i_ioexp_master.get_byte(1'b1, rx);
        chk("high byte", {8'h00, hi}, {8'h00, rx});
        i_ioexp_master.bus_stop();
        chk("sda", 16'h0001, {15'h0, s_oe_n});
    endtask
    task automatic t_reset();
        chk("port", 16'hFFFF, p_out);
        chk("drive", 16'hFFFF, p_oe_n);
        chk("alert", 16'h0001, {15'h0, alert_n});
    endtask
    task automatic t_write();
        xfer(8'h4A, 1'b1);
        put(8'h5A, 1'b1);
        port_is(16'hFFFF);
        put(8'h0F, 1'b1);
        port_is(16'h0F5A);
        chk("drive", 16'h0F5A, p_oe_n);
        put(8'hC3, 1'b1);
        put(8'h96, 1'b1);
        port_is(16'h96C3);
        put(8'h00, 1'b1);
        i_ioexp_master.bus_stop();
        port_is(16'h96C3);
    endtask
    task automatic t_refused();
        xfer(8'h40, 1'b0);
        i_ioexp_master.bus_stop();
        xfer(8'h00, 1'b0);
        i_ioexp_master.bus_stop();
        port_is(16'h96C3);
    endtask
    task automatic t_alert();
        xfer(8'h4A, 1'b1);
        put(8'hFF, 1'b1);
        put(8'hFF, 1'b1);
        i_ioexp_master.bus_stop();
        rd(8'hFF, 8'hFF);
        wait_alert(1'b1);
        ext[3] <= 1'b0;
        wait_alert(1'b0);
        xfer(8'h42, 1'b0);
        i_ioexp_master.bus_stop();
        chk("alert", 16'h0000, {15'h0, alert_n});
        @(posedge clk);
        ext[3] <= 1'b1;
        wait_alert(1'b1);
        ext[12] <= 1'b0;
        wait_alert(1'b0);
        rd(8'hFF, 8'hEF);
        wait_alert(1'b1);
        ext[0] <= 1'b0;
        wait_alert(1'b0);
        xfer(8'h4A, 1'b1);
        put(8'hFF, 1'b1);
        wait_alert(1'b1);
        put(8'hFF, 1'b1);
        i_ioexp_master.bus_stop();
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        rst_n <= 1'b0;
        strap <= 3'b101;
        ext <= 16'hFFFF;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset();
        t_write();
        t_refused();
        t_alert();
        end_of_test();
    end
endmodule
`default_nettype wire
